// [logic/ebm_params.svh]
// constants for the external bus pin and lane mapper
// assumes a single synchronous clock domain and no software bus
`ifndef EBM_PARAMS_SVH
`define EBM_PARAMS_SVH

`define EBM_ADDR_W           26
`define EBM_DATA_W           32
`define EBM_CS_W             6
`define EBM_SHARE_W          14
`define EBM_CSA_W            8
`define EBM_CSA_NAND_EN_BIT  3
`define EBM_CSA_UPPER_BIT    7
`define EBM_CSA_RST          8'h80
`define EBM_CS_NAND          3
`define EBM_CS_SDR           1
`define EBM_PIN_ALE          21
`define EBM_PIN_CLE          22
`define EBM_SDR_BA_LSB       16
`define EBM_SHR_DATA_LSB     0
`define EBM_SHR_A20          7
`define EBM_SHR_A23          8
`define EBM_SHR_CS2          11
`define EBM_SHR_CS4          12
`define EBM_SHR_CS5          13

`endif

// [logic/ebm_pkg.sv]
// types shared by the pin and lane mapper modules
// assumes ebm_params.svh supplies the numeric constants
package ebm_pkg;

    typedef enum logic [2:0] {
        EBM_LAY_8    = 3'b000,
        EBM_LAY_2X8  = 3'b001,
        EBM_LAY_16   = 3'b010,
        EBM_LAY_4X8  = 3'b011,
        EBM_LAY_2X16 = 3'b100,
        EBM_LAY_32   = 3'b101
    } ebm_layout_e;

    typedef enum logic [1:0] {
        EBM_OWN_IDLE = 2'b00,
        EBM_OWN_SMC  = 2'b01,
        EBM_OWN_SDR  = 2'b10,
        EBM_OWN_NAND = 2'b11
    } ebm_owner_e;

    typedef logic [31:0] ebm_word_t;

endpackage

// [logic/ebm_nand_if.sv]
// signals between the pin mapper core and its flash lane path
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
`default_nettype none

interface ebm_nand_if;
    logic              sel;
    logic              upper;
    logic              rd_n;
    logic              wr_n;
    logic              wdata_en;
    logic [15:0]       wdata;
    ebm_pkg::ebm_word_t dq_i;
    logic              oe_n;
    logic              we_n;
    ebm_pkg::ebm_word_t dq_o;
    ebm_pkg::ebm_word_t dq_oe_n;
    logic [15:0]       rdata;

    modport core (output sel, upper, rd_n, wr_n, wdata_en, wdata, dq_i,
                  input  oe_n, we_n, dq_o, dq_oe_n, rdata);
    modport path (input  sel, upper, rd_n, wr_n, wdata_en, wdata, dq_i,
                  output oe_n, we_n, dq_o, dq_oe_n, rdata);
endinterface

`default_nettype wire

// [logic/ebm_nand_path.sv]
// flash strobe gating and data lane steering, purely combinational
// assumes the core registers every result before it reaches a pin
`timescale 1ns/1ps
`default_nettype none

module ebm_nand_path (
    ebm_nand_if.path nif
);
    wire lo_drive_n;
    wire hi_drive_n;

    // strobes follow the static controller only inside chip select three
    assign nif.oe_n = nif.sel ? nif.rd_n : 1'b1;
    assign nif.we_n = nif.sel ? nif.wr_n : 1'b1;

    // flash data on the upper or lower sixteen lanes
    assign lo_drive_n  = ~(nif.sel & nif.wdata_en & ~nif.upper);
    assign hi_drive_n  = ~(nif.sel & nif.wdata_en & nif.upper);
    assign nif.dq_o    = nif.upper ? {nif.wdata, 16'h0000} : {16'h0000, nif.wdata};
    assign nif.dq_oe_n = {{16{hi_drive_n}}, {16{lo_drive_n}}};
    assign nif.rdata   = nif.upper ? nif.dq_i[31:16] : nif.dq_i[15:0];
endmodule

`default_nettype wire

// [logic/ebm_pin_mux.sv]
// external bus pin and lane mapper: controller strobes onto shared pins
// assumes all inputs are synchronous to clk_sys; pins are registered
`timescale 1ns/1ps
`include "ebm_params.svh"
`default_nettype none

// What this block does
// - two byte devices: strobe one upper, zero lower
// - four byte devices: strobe index equals lane
// - byte selects zero/one cover lower half
// - byte selects two/three cover upper half
// - upper lanes, addresses, selects shared with ports
// - flash data on low or upper lanes
// - lane select bit lives in assign register
// - lane select resets to one, upper lanes
// - flash strobes only while chip select three
// - address holds, controls go inactive while idle
module ebm_pin_mux (
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire logic                     cs_assign_wr,
    input  wire logic [`EBM_CSA_W-1:0]    cs_assign_wdata,
    output logic      [`EBM_CSA_W-1:0]    ext_bus_cs_assign_reg,
    input  wire logic [`EBM_CS_W-1:0]     smc_cs_n,
    input  wire logic                     smc_rd_n,
    input  wire logic                     smc_wr_n,
    input  wire logic [3:0]               smc_be_n,
    input  wire logic [`EBM_ADDR_W-1:0]   smc_addr,
    input  wire ebm_pkg::ebm_layout_e     smc_layout,
    input  wire logic [`EBM_DATA_W-1:0]   smc_wdata,
    input  wire logic                     smc_wdata_en,
    output logic      [`EBM_DATA_W-1:0]   smc_rdata,
    input  wire logic                     sdr_active,
    input  wire logic [12:0]              sdr_addr,
    input  wire logic [2:0]               sdr_ba,
    input  wire logic [3:0]               sdr_dqm_n,
    input  wire logic [`EBM_DATA_W-1:0]   sdr_wdata,
    input  wire logic                     sdr_wdata_en,
    input  wire logic [`EBM_SHARE_W-1:0]  pio_claim,
    output logic      [`EBM_SHARE_W-1:0]  shared_bus_en,
    output logic      [`EBM_ADDR_W-1:0]   pin_addr,
    output logic      [`EBM_CS_W-1:0]     pin_cs_n,
    output logic                          pin_rd_n,
    output logic                          pin_strobe0_n,
    output logic                          pin_strobe1_n,
    output logic                          pin_strobe3_n,
    output logic      [1:0]               pin_dqm_lo_n,
    output logic                          sdram_addr_bit_ten,
    output logic                          flash_read_strobe_n,
    output logic                          flash_write_strobe_n,
    input  wire logic [`EBM_DATA_W-1:0]   pin_dq_i,
    output logic      [`EBM_DATA_W-1:0]   pin_dq_o,
    output logic      [`EBM_DATA_W-1:0]   pin_dq_oe_n
);
    // device word address placed on the pins by layout width
    function automatic logic [`EBM_ADDR_W-1:0] addr_shift(
        input logic [`EBM_ADDR_W-1:0] a,
        input ebm_pkg::ebm_layout_e   lay
    );
        logic [`EBM_ADDR_W-1:0] r;
        r = a;
        unique case (lay)
            ebm_pkg::EBM_LAY_8:    r = a;
            ebm_pkg::EBM_LAY_2X8,
            ebm_pkg::EBM_LAY_16:   r = {a[`EBM_ADDR_W-2:0], 1'b0};
            ebm_pkg::EBM_LAY_4X8,
            ebm_pkg::EBM_LAY_2X16,
            ebm_pkg::EBM_LAY_32:   r = {a[`EBM_ADDR_W-3:0], 2'b00};
            default:               r = a;
        endcase
        return r;
    endfunction

    // per-lane active-low strobe from a common strobe and byte enables
    function automatic logic [3:0] lane_gate(
        input logic       strobe_n,
        input logic [3:0] be_n
    );
        return be_n | {4{strobe_n}};
    endfunction

    ebm_nand_if nif ();

    ebm_nand_path u_nand_path (
        .nif (nif)
    );

    logic [`EBM_CSA_W-1:0]   csa_r;
    logic [`EBM_ADDR_W-1:0]  addr_r;
    logic [`EBM_CS_W-1:0]    cs_r;
    logic                    rd_r;
    logic                    st0_r;
    logic                    st1_r;
    logic                    st3_r;
    logic [1:0]              dqm_r;
    logic                    sdram_addr_bit_ten_r;
    logic                    foe_r;
    logic                    fwe_r;
    logic [`EBM_DATA_W-1:0]  dq_o_r;
    logic [`EBM_DATA_W-1:0]  dq_oe_r;
    logic [`EBM_DATA_W-1:0]  rdata_r;
    logic [`EBM_SHARE_W-1:0] shr_r;

    wire                     nand_en;
    wire                     cs3_act;
    wire                     smc_act;
    wire                     byte_write;
    wire                     byte_sel;
    wire                     is_8;
    wire                     is_4x8;
    wire                     is_wide_bs;
    wire [3:0]               ws_n;
    wire [3:0]               bs_n;
    wire [`EBM_ADDR_W-1:0]   smc_sh;
    wire [`EBM_ADDR_W-1:0]   smc_pa;
    wire [`EBM_ADDR_W-1:0]   nand_pa;
    wire [`EBM_ADDR_W-1:0]   sdr_pa;
    wire [`EBM_DATA_W-1:0]   share_mask_n;
    ebm_pkg::ebm_owner_e     owner;

    wire [`EBM_CSA_W-1:0]    csa_nxt;
    wire [`EBM_ADDR_W-1:0]   addr_nxt;
    wire [`EBM_CS_W-1:0]     cs_nxt;
    wire                     rd_nxt;
    wire                     st0_nxt;
    wire                     st1_nxt;
    wire                     st3_nxt;
    wire [1:0]               dqm_nxt;
    wire                     sdram_addr_bit_ten_nxt;
    wire [`EBM_DATA_W-1:0]   dq_o_nxt;
    wire [`EBM_DATA_W-1:0]   dq_oe_nxt;
    wire [`EBM_DATA_W-1:0]   rdata_nxt;

    // assign register holds the flash enable and lane select
    assign csa_nxt = cs_assign_wr ? cs_assign_wdata : csa_r;
    assign nand_en = csa_r[`EBM_CSA_NAND_EN_BIT];
    assign cs3_act = ~smc_cs_n[`EBM_CS_NAND];
    assign smc_act = ~&smc_cs_n;

    assign owner = sdr_active           ? ebm_pkg::EBM_OWN_SDR  :
                   (cs3_act && nand_en) ? ebm_pkg::EBM_OWN_NAND :
                   smc_act              ? ebm_pkg::EBM_OWN_SMC  : ebm_pkg::EBM_OWN_IDLE;

    // layout classes
    assign is_8       = smc_layout == ebm_pkg::EBM_LAY_8;
    assign is_4x8     = smc_layout == ebm_pkg::EBM_LAY_4X8;
    assign byte_write = (smc_layout == ebm_pkg::EBM_LAY_2X8) || is_4x8;
    assign is_wide_bs = (smc_layout == ebm_pkg::EBM_LAY_2X16) ||
                        (smc_layout == ebm_pkg::EBM_LAY_32);
    assign byte_sel   = is_wide_bs || (smc_layout == ebm_pkg::EBM_LAY_16);

    assign ws_n = lane_gate(smc_wr_n, smc_be_n);
    assign bs_n = smc_be_n;

    // static address: width shift with strobe overlays on pins zero and one
    assign smc_sh = addr_shift(smc_addr, smc_layout);
    assign smc_pa = {smc_sh[`EBM_ADDR_W-1:2],
                     is_4x8 ? ws_n[2] : is_wide_bs ? bs_n[2] : smc_sh[1],
                     is_8 ? smc_sh[0] : byte_sel ? bs_n[0] : 1'b1};

    // flash latch enables ride on their own address pins
    assign nand_pa = {smc_addr[`EBM_ADDR_W-1:`EBM_PIN_CLE+1],
                      smc_addr[`EBM_PIN_CLE], smc_addr[`EBM_PIN_ALE],
                      smc_addr[`EBM_PIN_ALE-1:0]};

    // sdram row and column from pin two upward, bank above
    assign sdr_pa = {addr_r[`EBM_ADDR_W-1:`EBM_SDR_BA_LSB+3], sdr_ba, 1'b0,
                     sdr_addr[12:11], 1'b0, sdr_addr[9:0], sdr_dqm_n[2], 1'b1};

    // address holds whenever no access is running
    assign addr_nxt = (owner == ebm_pkg::EBM_OWN_SMC)  ? smc_pa  :
                      (owner == ebm_pkg::EBM_OWN_NAND) ? nand_pa :
                      (owner == ebm_pkg::EBM_OWN_SDR)  ? sdr_pa  : addr_r;

    assign cs_nxt = sdr_active ? (smc_cs_n & ~(6'h01 << `EBM_CS_SDR)) : smc_cs_n;

    // controls rest inactive outside an access
    assign rd_nxt  = (owner == ebm_pkg::EBM_OWN_SMC) ? smc_rd_n : 1'b1;
    assign st0_nxt = (owner != ebm_pkg::EBM_OWN_SMC) ? 1'b1 :
                     byte_write ? ws_n[0] : smc_wr_n;
    assign st1_nxt = (owner != ebm_pkg::EBM_OWN_SMC) ? 1'b1 :
                     byte_write ? ws_n[1] : byte_sel ? bs_n[1] : 1'b1;
    assign st3_nxt = (owner == ebm_pkg::EBM_OWN_SDR) ? sdr_dqm_n[3] :
                     (owner != ebm_pkg::EBM_OWN_SMC) ? 1'b1 :
                     is_4x8 ? ws_n[3] : is_wide_bs ? bs_n[3] : 1'b1;
    assign dqm_nxt   = (owner == ebm_pkg::EBM_OWN_SDR) ? sdr_dqm_n[1:0] : 2'b11;
    assign sdram_addr_bit_ten_nxt = (owner == ebm_pkg::EBM_OWN_SDR) ? sdr_addr[10] : sdram_addr_bit_ten_r;

    // flash lane path
    assign nif.sel      = owner == ebm_pkg::EBM_OWN_NAND;
    assign nif.upper    = csa_r[`EBM_CSA_UPPER_BIT];
    assign nif.rd_n     = smc_rd_n;
    assign nif.wr_n     = smc_wr_n;
    assign nif.wdata_en = smc_wdata_en;
    assign nif.wdata    = smc_wdata[15:0];
    assign nif.dq_i     = pin_dq_i;

    // data drive per owner, upper shared lanes released when claimed
    assign share_mask_n = {pio_claim[`EBM_SHR_DATA_LSB+6:`EBM_SHR_DATA_LSB], 25'h0000000};
    assign dq_o_nxt  = (owner == ebm_pkg::EBM_OWN_NAND) ? nif.dq_o :
                       (owner == ebm_pkg::EBM_OWN_SDR && sdr_wdata_en) ? sdr_wdata :
                       (owner == ebm_pkg::EBM_OWN_SMC && smc_wdata_en) ? smc_wdata : dq_o_r;
    assign dq_oe_nxt = share_mask_n |
                       ((owner == ebm_pkg::EBM_OWN_NAND) ? nif.dq_oe_n :
                        (owner == ebm_pkg::EBM_OWN_SDR && sdr_wdata_en) ? 32'h00000000 :
                        (owner == ebm_pkg::EBM_OWN_SMC && smc_wdata_en) ? 32'h00000000 :
                        32'hffffffff);
    assign rdata_nxt = (owner == ebm_pkg::EBM_OWN_NAND) ? {16'h0000, nif.rdata} : pin_dq_i;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            csa_r   <= `EBM_CSA_RST;
            addr_r  <= '0;
            cs_r    <= '1;
            rd_r    <= 1'b1;
            st0_r   <= 1'b1;
            st1_r   <= 1'b1;
            st3_r   <= 1'b1;
            dqm_r   <= 2'b11;
            sdram_addr_bit_ten_r <= 1'b0;
            foe_r   <= 1'b1;
            fwe_r   <= 1'b1;
            dq_o_r  <= '0;
            dq_oe_r <= '1;
            rdata_r <= '0;
            shr_r   <= '0;
        end else begin
            csa_r   <= csa_nxt;
            addr_r  <= addr_nxt;
            cs_r    <= cs_nxt;
            rd_r    <= rd_nxt;
            st0_r   <= st0_nxt;
            st1_r   <= st1_nxt;
            st3_r   <= st3_nxt;
            dqm_r   <= dqm_nxt;
            sdram_addr_bit_ten_r <= sdram_addr_bit_ten_nxt;
            foe_r   <= nif.oe_n;
            fwe_r   <= nif.we_n;
            dq_o_r  <= dq_o_nxt;
            dq_oe_r <= dq_oe_nxt;
            rdata_r <= rdata_nxt;
            shr_r   <= ~pio_claim;
        end
    end

    assign ext_bus_cs_assign_reg = csa_r;
    assign smc_rdata             = rdata_r;
    assign shared_bus_en         = shr_r;
    assign pin_addr              = addr_r;
    assign pin_cs_n              = cs_r;
    assign pin_rd_n              = rd_r;
    assign pin_strobe0_n         = st0_r;
    assign pin_strobe1_n         = st1_r;
    assign pin_strobe3_n         = st3_r;
    assign pin_dqm_lo_n          = dqm_r;
    assign sdram_addr_bit_ten    = sdram_addr_bit_ten_r;
    assign flash_read_strobe_n   = foe_r;
    assign flash_write_strobe_n  = fwe_r;
    assign pin_dq_o              = dq_o_r;
    assign pin_dq_oe_n           = dq_oe_r;
endmodule

`default_nettype wire

// [verif/ebm_pin_mux_checker.sv]
// assertions on the pin mapper top ports
// assumes a bind onto ebm_pin_mux and one clock domain
`timescale 1ns/1ps
`include "ebm_params.svh"
`default_nettype none

module ebm_pin_mux_checker (
    input wire logic                   clk_sys,
    input wire logic                   sys_rst,
    input wire logic                   cs_assign_wr,
    input wire logic [`EBM_CSA_W-1:0]  cs_assign_wdata,
    input wire logic [`EBM_CSA_W-1:0]  ext_bus_cs_assign_reg,
    input wire logic [`EBM_CS_W-1:0]   smc_cs_n,
    input wire logic                   smc_rd_n,
    input wire logic                   smc_wr_n,
    input wire logic [3:0]             smc_be_n,
    input wire ebm_pkg::ebm_layout_e   smc_layout,
    input wire logic                   smc_wdata_en,
    input wire logic                   sdr_active,
    input wire logic [2:0]             sdr_ba,
    input wire logic [`EBM_SHARE_W-1:0] pio_claim,
    input wire logic [`EBM_SHARE_W-1:0] shared_bus_en,
    input wire logic [`EBM_ADDR_W-1:0] pin_addr,
    input wire logic [`EBM_CS_W-1:0]   pin_cs_n,
    input wire logic                   pin_rd_n,
    input wire logic                   pin_strobe0_n,
    input wire logic                   pin_strobe1_n,
    input wire logic                   pin_strobe3_n,
    input wire logic                   flash_read_strobe_n,
    input wire logic                   flash_write_strobe_n,
    input wire logic [`EBM_DATA_W-1:0] pin_dq_oe_n
);
    logic live_r;
    wire logic fl   = !sdr_active && !smc_cs_n[3] && ext_bus_cs_assign_reg[3];
    wire logic st   = !sdr_active && !fl && (smc_cs_n != 6'h3f);
    wire logic idle = !sdr_active && (smc_cs_n == 6'h3f);

    always_ff @(posedge clk_sys) begin
        live_r <= !sys_rst;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst || !live_r);

    a_reset_value: assert property (disable iff (1'b0)
        sys_rst |=> ext_bus_cs_assign_reg == 8'h80) else $error("assign reg reset value wrong");
    a_assign_take: assert property (
        cs_assign_wr |=> ext_bus_cs_assign_reg == $past(cs_assign_wdata)) else $error("assign lost");
    a_flash_read_gate: assert property (
        !flash_read_strobe_n == $past(fl && !smc_rd_n)) else $error("flash read strobe wrong");
    a_flash_write_gate: assert property (
        !flash_write_strobe_n == $past(fl && !smc_wr_n)) else $error("flash write strobe wrong");
    a_idle_hold: assert property ($past(idle) |-> $stable(pin_addr) && pin_rd_n
        && pin_strobe0_n && flash_write_strobe_n) else $error("idle pins moved");
    a_share_follow: assert property (
        shared_bus_en == ~$past(pio_claim)) else $error("shared enable wrong");
    a_flash_lane_pick: assert property ($past(fl && smc_wdata_en && pio_claim == 0) |->
        pin_dq_oe_n == ($past(ext_bus_cs_assign_reg[7]) ? 32'h0000ffff : 32'hffff0000))
        else $error("flash lane wrong");
    a_quad_byte_write: assert property ($past(st && smc_layout == ebm_pkg::EBM_LAY_4X8) |->
        {pin_strobe3_n, pin_addr[1], pin_strobe1_n, pin_strobe0_n}
        == $past({4{smc_wr_n}} | smc_be_n)) else $error("quad strobe wrong");
    a_pair_byte_write: assert property ($past(st && smc_layout == ebm_pkg::EBM_LAY_2X8) |->
        {pin_strobe1_n, pin_strobe0_n} == $past({2{smc_wr_n}} | smc_be_n[1:0]))
        else $error("pair strobe wrong");
    a_byte_select: assert property ($past(st && smc_layout inside
        {ebm_pkg::EBM_LAY_2X16, ebm_pkg::EBM_LAY_32}) |-> {pin_strobe3_n, pin_addr[1],
        pin_strobe1_n, pin_addr[0]} == $past(smc_be_n)) else $error("byte select wrong");
    a_sdram_select: assert property ($past(sdr_active) |-> !pin_cs_n[1] && pin_addr[0]
        && pin_addr[18:16] == $past(sdr_ba)) else $error("sdram pins wrong");
endmodule

`default_nettype wire

// [verif/ebm_mem_model.sv]
// far side memory model: answers reads on the data pins
// assumes strobes from the pin mapper, active low
`timescale 1ns/1ps
`default_nettype none

module ebm_mem_model #(
    parameter logic [31:0] RD_WORD = 32'h5aa5c33c
) (
    input  wire logic        clk_sys,
    input  wire logic        pin_rd_n,
    input  wire logic        flash_read_strobe_n,
    output logic      [31:0] pin_dq_i
);
    initial pin_dq_i = 32'h0f0f0f0f;
    // read word while a read strobe is low, toggling junk otherwise
    always @(posedge clk_sys) begin
        pin_dq_i <= (!pin_rd_n || !flash_read_strobe_n) ? RD_WORD : ~pin_dq_i;
    end
endmodule

`default_nettype wire

// [verif/ebm_pin_mux_tb.sv]
// self-checking bench for the pin and lane mapper
// assumes ebm_mem_model on the data pins and the bound checker
`timescale 1ns/1ps
`include "ebm_params.svh"
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end

module ebm_pin_mux_tb;
    localparam logic [25:0] ADR = 26'h00012a5;
    localparam logic [31:0] RD  = 32'h5aa5c33c;
    logic clk_sys, sys_rst, cs_assign_wr, smc_rd_n, smc_wr_n, smc_wdata_en;
    logic sdr_active, sdr_wdata_en, pin_rd_n, pin_strobe0_n, pin_strobe1_n, pin_strobe3_n;
    logic sdram_addr_bit_ten, flash_read_strobe_n, flash_write_strobe_n;
    logic [7:0]  cs_assign_wdata, ext_bus_cs_assign_reg;
    logic [5:0]  smc_cs_n, pin_cs_n;
    logic [3:0]  smc_be_n, sdr_dqm_n;
    logic [25:0] smc_addr, pin_addr, last_ea;
    logic [31:0] smc_wdata, smc_rdata, sdr_wdata, pin_dq_i, pin_dq_o, pin_dq_oe_n;
    logic [12:0] sdr_addr;
    logic [2:0]  sdr_ba;
    logic [13:0] pio_claim, shared_bus_en;
    logic [1:0]  pin_dqm_lo_n;
    ebm_pkg::ebm_layout_e smc_layout;
    int n_fail, checked, cyc;

    ebm_pin_mux dut (.clk_sys, .sys_rst, .cs_assign_wr, .cs_assign_wdata, .ext_bus_cs_assign_reg,
        .smc_cs_n, .smc_rd_n, .smc_wr_n, .smc_be_n, .smc_addr, .smc_layout, .smc_wdata,
        .smc_wdata_en, .smc_rdata, .sdr_active, .sdr_addr, .sdr_ba, .sdr_dqm_n, .sdr_wdata,
        .sdr_wdata_en, .pio_claim, .shared_bus_en, .pin_addr, .pin_cs_n, .pin_rd_n,
        .pin_strobe0_n, .pin_strobe1_n, .pin_strobe3_n, .pin_dqm_lo_n, .sdram_addr_bit_ten,
        .flash_read_strobe_n, .flash_write_strobe_n, .pin_dq_i, .pin_dq_o, .pin_dq_oe_n);
    ebm_mem_model mem (.clk_sys, .pin_rd_n, .flash_read_strobe_n, .pin_dq_i);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic settle;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic t_static(ebm_pkg::ebm_layout_e lay, logic [3:0] be, logic wr);
        logic [25:0] ea;
        logic [2:0]  es;
        logic [3:0]  b;
        b = be | {4{wr}};
        ea = ADR << 2;
        case (lay)
            ebm_pkg::EBM_LAY_8:   begin ea = ADR; es = {2'b11, wr}; end
            ebm_pkg::EBM_LAY_2X8: begin ea = {ADR[24:0], 1'b1}; es = {1'b1, b[1:0]}; end
            ebm_pkg::EBM_LAY_16:  begin ea = {ADR[24:0], be[0]}; es = {1'b1, be[1], wr}; end
            ebm_pkg::EBM_LAY_4X8: begin ea[1:0] = {b[2], 1'b1}; es = {b[3], b[1], b[0]}; end
            default:              begin ea[1:0] = {be[2], be[0]}; es = {be[3], be[1], wr}; end
        endcase
        @(posedge clk_sys);
        smc_cs_n <= 6'h3e; smc_layout <= lay; smc_be_n <= be; smc_wr_n <= wr; smc_rd_n <= ~wr;
        settle();
        `CHK("addr", ea, pin_addr)
        `CHK("strobes", es, {pin_strobe3_n, pin_strobe1_n, pin_strobe0_n})
        `CHK("rd", ~wr, pin_rd_n)
        last_ea = ea;
    endtask

    task automatic t_idle;
        @(posedge clk_sys);
        smc_cs_n <= 6'h3f; smc_addr <= 26'h3fff0f0; smc_wr_n <= 1'b0;
        repeat (2) settle();
        `CHK("idle addr", last_ea, pin_addr)
        `CHK("idle ctl", 2'b11, {pin_rd_n, pin_strobe0_n})
        @(posedge clk_sys);
        smc_addr <= ADR; smc_wr_n <= 1'b1;
    endtask

    task automatic t_assign(logic [7:0] v);
        @(posedge clk_sys);
        cs_assign_wr <= 1'b1; cs_assign_wdata <= v;
        @(posedge clk_sys);
        cs_assign_wr <= 1'b0;
        #1;
        `CHK("assign", v, ext_bus_cs_assign_reg)
    endtask

    task automatic t_flash(logic up);
        t_assign({up, 7'h5a});
        @(posedge clk_sys);
        smc_cs_n <= 6'h37; smc_addr <= 26'h0200005; smc_wr_n <= 1'b0; smc_rd_n <= 1'b1;
        smc_wdata_en <= 1'b1; smc_wdata <= 32'h0000c3a7;
        settle();
        `CHK("fl we", 1'b0, flash_write_strobe_n)
        `CHK("st we", 1'b1, pin_strobe0_n)
        `CHK("fl addr", 26'h0200005, pin_addr)
        `CHK("fl oe", up ? 32'h0000ffff : 32'hffff0000, pin_dq_oe_n)
        `CHK("fl wd", 16'hc3a7, up ? pin_dq_o[31:16] : pin_dq_o[15:0])
        @(posedge clk_sys);
        smc_wr_n <= 1'b1; smc_rd_n <= 1'b0; smc_wdata_en <= 1'b0;
        repeat (3) settle();
        `CHK("fl re", 1'b0, flash_read_strobe_n)
        `CHK("fl rd", up ? RD[31:16] : RD[15:0], smc_rdata[15:0])
        @(posedge clk_sys);
        smc_cs_n <= 6'h3e;
        repeat (2) settle();
        `CHK("fl off", 2'b11, {flash_read_strobe_n, flash_write_strobe_n})
        @(posedge clk_sys);
        smc_cs_n <= 6'h3f; smc_rd_n <= 1'b1;
    endtask

    task automatic t_sdram;
        @(posedge clk_sys);
        sdr_active <= 1'b1; sdr_addr <= 13'h1ebc; sdr_ba <= 3'h5; sdr_dqm_n <= 4'b0110;
        smc_cs_n <= 6'h3e; smc_wr_n <= 1'b0;
        sdr_wdata <= 32'h96e14b2d; sdr_wdata_en <= 1'b1;
        settle();
        `CHK("sd cs", 1'b0, pin_cs_n[1])
        `CHK("sd wd", 32'h96e14b2d, pin_dq_o)
        `CHK("sd oe", 32'h00000000, pin_dq_oe_n)
        `CHK("sd addr", {3'h5, 1'b0, 2'b11, 1'b0, 10'h2bc, 2'b11}, pin_addr[18:0])
        `CHK("sd a10", 1'b1, sdram_addr_bit_ten)
        `CHK("sd dqm", 4'b0110, {pin_strobe3_n, pin_addr[1], pin_dqm_lo_n})
        `CHK("sd st", 1'b1, pin_strobe0_n)
        @(posedge clk_sys);
        sdr_active <= 1'b0; smc_cs_n <= 6'h3f; smc_wr_n <= 1'b1; sdr_wdata_en <= 1'b0;
    endtask

    task automatic t_share;
        @(posedge clk_sys);
        pio_claim <= 14'h007f; smc_cs_n <= 6'h3e; smc_layout <= ebm_pkg::EBM_LAY_32;
        smc_wr_n <= 1'b0; smc_wdata_en <= 1'b1;
        settle();
        `CHK("share", 14'h3f80, shared_bus_en)
        `CHK("claimed", 7'h7f, pin_dq_oe_n[31:25])
        `CHK("unclaimed", 25'h0000000, pin_dq_oe_n[24:0])
        @(posedge clk_sys);
        pio_claim <= 14'h3f80;
        settle();
        `CHK("share2", 14'h007f, shared_bus_en)
        `CHK("reclaim", 32'h00000000, pin_dq_oe_n)
        @(posedge clk_sys);
        smc_cs_n <= 6'h3f; smc_wr_n <= 1'b1; smc_wdata_en <= 1'b0; pio_claim <= 14'h0;
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1; cs_assign_wr = 1'b0; cs_assign_wdata = 8'h0; smc_cs_n = 6'h3f;
        smc_rd_n = 1'b1; smc_wr_n = 1'b1; smc_be_n = 4'hf; smc_addr = ADR; smc_wdata = 32'h0;
        smc_layout = ebm_pkg::EBM_LAY_8; smc_wdata_en = 1'b0; sdr_active = 1'b0;
        sdr_addr = 13'h0; sdr_ba = 3'h0; sdr_dqm_n = 4'hf; sdr_wdata = 32'h0;
        sdr_wdata_en = 1'b0; pio_claim = 14'h0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        settle();
        `CHK("rst reg", 8'h80, ext_bus_cs_assign_reg)
        `CHK("rst oe", 32'hffffffff, pin_dq_oe_n)
        for (int i = 0; i < 6; i++) begin
            t_static(ebm_pkg::ebm_layout_e'(i[2:0]), 4'b1010, 1'b0);
            t_static(ebm_pkg::ebm_layout_e'(i[2:0]), 4'b1010, 1'b1);
        end
        t_static(ebm_pkg::EBM_LAY_4X8, 4'b0101, 1'b0);
        t_idle();
        t_flash(1'b1);
        t_flash(1'b0);
        t_sdram();
        t_share();
        finish_test();
    end
endmodule

bind ebm_pin_mux ebm_pin_mux_checker chk (.clk_sys, .sys_rst, .cs_assign_wr, .cs_assign_wdata,
    .ext_bus_cs_assign_reg, .smc_cs_n, .smc_rd_n, .smc_wr_n, .smc_be_n, .smc_layout,
    .smc_wdata_en, .sdr_active, .sdr_ba, .pio_claim, .shared_bus_en, .pin_addr, .pin_cs_n,
    .pin_rd_n, .pin_strobe0_n, .pin_strobe1_n, .pin_strobe3_n, .flash_read_strobe_n,
    .flash_write_strobe_n, .pin_dq_oe_n);

`default_nettype wire
